/* rtl/sel_pkg.sv */
// Purpose: Shared constants and types for the serial memory configuration loader.
// Assumes: SPI-style byte-wide memory, image parsed as id, count and 6-byte records.
// Notes: Opcodes follow the common SPI memory instruction set.
package sel_pkg;

    // Memory instruction opcodes.
    localparam logic [7:0] OPC_READ = 8'h03;
    localparam logic [7:0] OPC_WRITE = 8'h02;
    localparam logic [7:0] OPC_WRITE_LATCH_SET = 8'h06;
    localparam logic [7:0] OPC_STATUS_FETCH = 8'h05;
    localparam int OPC_ADDR8_BIT = 3;
    localparam int STATUS_BUSY_BIT = 0;

    // Image layout.
    localparam logic [15:0] ADDR_ID = 16'h0000;
    localparam logic [15:0] ADDR_COUNT = 16'h0002;
    localparam logic [16:0] ADDR_FIRST_REC = 17'h00004;
    localparam logic [16:0] REC_STRIDE = 17'h00006;
    localparam logic [16:0] ADDR_LAST_REC = 17'h0fffa;
    localparam logic [15:0] REC_LEN = 16'h0006;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    localparam logic [2:0] ID_BYTES = 3'h2;
    localparam logic [2:0] COUNT_BYTES = 3'h2;
    localparam logic [2:0] REC_BYTES = 3'h6;
    localparam logic [2:0] ONE_BYTE = 3'h1;

    // Byte positions inside a received record, first byte received is index 5.
    localparam int REC_ADDR_LO = 5;
    localparam int REC_BE_ADDR_HI = 4;
    localparam int REC_DATA_B0 = 3;
    localparam int REC_DATA_B1 = 2;
    localparam int REC_DATA_B2 = 1;
    localparam int REC_DATA_B3 = 0;

    // Serial clock half period in link clock cycles, minus one.
    localparam logic [2:0] SCLK_HALF_M1 = 3'h7;
    localparam logic [5:0] LEN_OPC = 6'h08;
    localparam logic [5:0] LEN_ADDR9 = 6'h10;
    localparam logic [5:0] LEN_ADDR16 = 6'h18;
    localparam logic [5:0] LEN_WR9 = 6'h18;
    localparam logic [5:0] LEN_WR16 = 6'h20;

    typedef enum logic [1:0] {SEL_OP_READ, SEL_OP_WRITE_LATCH_SET_COMMAND, SEL_OP_WRITE, SEL_OP_STATUS_FETCH_COMMAND} sel_op_t;
    typedef enum logic [1:0] {SEL_CPL_NORMAL, SEL_CPL_RETRY, SEL_CPL_UNSUPPORTED} sel_cpl_t;

    typedef struct packed {
        sel_op_t op;
        logic mode16;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic [2:0] nbytes;
    } sel_cmd_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [3:0] be;
        logic [31:0] data;
    } sel_csr_wr_t;

    typedef logic [5:0][7:0] sel_rec_t;

    function automatic sel_csr_wr_t selDecodeRecord(input sel_rec_t raw);
        sel_csr_wr_t w;
        w.addr = {raw[REC_BE_ADDR_HI][3:0], raw[REC_ADDR_LO]};
        w.be = raw[REC_BE_ADDR_HI][7:4];
        w.data = {raw[REC_DATA_B3], raw[REC_DATA_B2], raw[REC_DATA_B1], raw[REC_DATA_B0]};
        return w;
    endfunction

endpackage

/* rtl/sel_link_engine.sv */
// Purpose: Serial engine on the link clock that runs one memory instruction per request.
// Assumes: Command is held stable by the core from request toggle until acknowledge toggle.
// Notes: Serial clock is the link clock divided by sixteen and idles low.
`timescale 1ns/10ps
module sel_link_engine import sel_pkg::*; (
    input wire logic linkClk,
    input wire logic sys_rst,
    input wire logic reqTgl,
    input wire sel_cmd_t cmd,
    output logic ackTgl,
    output logic [47:0] rxData,
    output logic memSerialClock,
    output logic loaderSerialOut,
    output logic memSelectN,
    input wire logic memorySerialReturn
);

    typedef enum logic [1:0] {L_IDLE, L_ACT, L_END} sel_lstate_t;

    logic lrstA_r, linkRst_r;
    logic reqS1_r, reqS2_r, reqS3_r;
    logic retS1_r, retS2_r, retS3_r, retLvl_r;
    sel_lstate_t state_r;
    logic [31:0] txSh_r;
    logic [5:0] txLen_r;
    logic [6:0] totLen_r, bitCnt_r;
    logic [2:0] half_r;
    logic [47:0] rxSh_r;
    logic [7:0] opc;
    logic [31:0] txWord;
    logic [5:0] txLen;
    logic [6:0] rxLen;
    logic reqNew;

    // Reset release is retimed to the link clock.
    always_ff @(posedge linkClk or posedge sys_rst) begin
        if (sys_rst) begin
            lrstA_r <= 1'b1;
            linkRst_r <= 1'b1;
        end else begin
            lrstA_r <= 1'b0;
            linkRst_r <= lrstA_r;
        end
    end

    always_ff @(posedge linkClk or posedge linkRst_r) begin
        if (linkRst_r) begin
            reqS1_r <= 1'b0;
            reqS2_r <= 1'b0;
            reqS3_r <= 1'b0;
        end else begin
            reqS1_r <= reqTgl;
            reqS2_r <= reqS1_r;
            reqS3_r <= reqS2_r;
        end
    end
    assign reqNew = reqS2_r ^ reqS3_r;

    // Return line filter: a change counts once the last two stages agree.
    always_ff @(posedge linkClk or posedge linkRst_r) begin
        if (linkRst_r) begin
            retS1_r <= 1'b0;
            retS2_r <= 1'b0;
            retS3_r <= 1'b0;
            retLvl_r <= 1'b0;
        end else begin
            retS1_r <= memorySerialReturn;
            retS2_r <= retS1_r;
            retS3_r <= retS2_r;
            if (retS2_r == retS3_r) begin
                retLvl_r <= retS3_r;
            end
        end
    end

    always_comb begin
        opc = OPC_READ;
        txLen = LEN_OPC;
        rxLen = 7'h00;
        unique case (cmd.op)
            SEL_OP_READ: begin
                opc = OPC_READ;
                txLen = cmd.mode16 ? LEN_ADDR16 : LEN_ADDR9;
                rxLen = {1'b0, cmd.nbytes, 3'h0};
            end
            SEL_OP_WRITE_LATCH_SET_COMMAND: begin
                opc = OPC_WRITE_LATCH_SET;
            end
            SEL_OP_WRITE: begin
                opc = OPC_WRITE;
                txLen = cmd.mode16 ? LEN_WR16 : LEN_WR9;
            end
            SEL_OP_STATUS_FETCH_COMMAND: begin
                opc = OPC_STATUS_FETCH;
                rxLen = {1'b0, ONE_BYTE, 3'h0};
            end
        endcase
        if (cmd.mode16) begin
            txWord = {opc, cmd.addr, cmd.wdata};
        end else begin
            opc[OPC_ADDR8_BIT] = opc[OPC_ADDR8_BIT] | cmd.addr[8];
            txWord = {opc, cmd.addr[7:0], cmd.wdata, 8'h00};
        end
    end

    always_ff @(posedge linkClk or posedge linkRst_r) begin
        if (linkRst_r) begin
            state_r <= L_IDLE;
            txSh_r <= 32'h0;
            txLen_r <= 6'h0;
            totLen_r <= 7'h0;
            bitCnt_r <= 7'h0;
            half_r <= 3'h0;
            rxSh_r <= 48'h0;
            rxData <= 48'h0;
            ackTgl <= 1'b0;
            memSerialClock <= 1'b0;
            loaderSerialOut <= 1'b0;
            memSelectN <= 1'b1;
        end else begin
            unique case (state_r)
                L_IDLE: begin
                    if (reqNew) begin
                        state_r <= L_ACT;
                        txSh_r <= txWord;
                        txLen_r <= txLen;
                        totLen_r <= {1'b0, txLen} + rxLen;
                        bitCnt_r <= 7'h0;
                        half_r <= 3'h0;
                        rxSh_r <= 48'h0;
                        memSelectN <= 1'b0;
                        loaderSerialOut <= txWord[31];
                    end
                end
                L_ACT: begin
                    half_r <= half_r + 3'h1;
                    if (half_r == SCLK_HALF_M1) begin
                        memSerialClock <= ~memSerialClock;
                        if (!memSerialClock) begin
                            if (bitCnt_r >= {1'b0, txLen_r}) begin
                                rxSh_r <= {rxSh_r[46:0], retLvl_r};
                            end
                        end else if (bitCnt_r == totLen_r - 7'h1) begin
                            state_r <= L_END;
                            loaderSerialOut <= 1'b0;
                        end else begin
                            bitCnt_r <= bitCnt_r + 7'h1;
                            txSh_r <= {txSh_r[30:0], 1'b0};
                            loaderSerialOut <= txSh_r[30];
                        end
                    end
                end
                L_END: begin
                    memSelectN <= 1'b1;
                    half_r <= half_r + 3'h1;
                    if (half_r == SCLK_HALF_M1) begin
                        state_r <= L_IDLE;
                        rxData <= rxSh_r;
                        ackTgl <= ~ackTgl;
                    end
                end
                default: state_r <= L_IDLE;
            endcase
        end
    end

endmodule // sel_link_engine

/* rtl/sel_loader.sv */
// Purpose: Loads configuration registers from a serial memory image after reset.
// Assumes: Memory answers standard read, write, write-latch and status instructions.
// Notes: Serial pins run in the link clock domain inside the engine instance.
`timescale 1ns/10ps
module sel_loader import sel_pkg::*; #(
    // Identity value is arbitrary here; set it to match the stored image.
    parameter logic [15:0] ID_CODE = 16'h5a3c
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic linkClk,
    output logic memSerialClock,
    output logic loaderSerialOut,
    output logic memSelectN,
    input wire logic memorySerialReturn,
    output sel_csr_wr_t csrWr,
    output logic csrWrValid,
    output logic loadBusy,
    output logic loadDone,
    output logic memPresent,
    output logic addrMode16,
    input wire logic swMode16,
    input wire logic swWriteReq,
    input wire logic swReadReq,
    input wire logic [15:0] swAddr,
    input wire logic [7:0] swData,
    output logic swBusy,
    output logic [7:0] swReadData,
    output logic swReadValid,
    input wire logic cfgReqValid,
    input wire logic cfgReqIsConfig,
    output logic cplValid,
    output sel_cpl_t cplKind
);

    typedef enum logic [3:0] {
        C_ID9, C_ID16, C_COUNT, C_REC, C_IDLE, C_WRITE_LATCH_SET_COMMAND, C_WRITE, C_POLL, C_READ
    } sel_cstate_t;

    sel_cstate_t state_r;
    sel_cmd_t cmd_r, cmdNxt;
    logic reqTgl_r, pend_r;
    logic ackS1_r, ackS2_r, ackS3_r;
    logic ackEv;
    logic linkAck;
    logic [47:0] linkRx;
    logic [15:0] remain_r;
    logic [16:0] recAddr_r;
    logic [15:0] swAddr_r;
    logic [7:0] swData_r;
    logic mode16_r, present_r, done_r;
    logic [15:0] idRead, countRead;
    logic lastRec;
    logic useMode16;

    sel_link_engine u_engine (
        .linkClk(linkClk),
        .sys_rst(sys_rst),
        .reqTgl(reqTgl_r),
        .cmd(cmd_r),
        .ackTgl(linkAck),
        .rxData(linkRx),
        .memSerialClock(memSerialClock),
        .loaderSerialOut(loaderSerialOut),
        .memSelectN(memSelectN),
        .memorySerialReturn(memorySerialReturn)
    );

    // Acknowledge toggle comes back from the link domain.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ackS1_r <= 1'b0;
            ackS2_r <= 1'b0;
            ackS3_r <= 1'b0;
        end else begin
            ackS1_r <= linkAck;
            ackS2_r <= ackS1_r;
            ackS3_r <= ackS2_r;
        end
    end
    assign ackEv = ackS2_r ^ ackS3_r;

    // The first byte read is the low byte of both the identity and the count.
    assign idRead = {linkRx[7:0], linkRx[15:8]};
    assign countRead = {linkRx[7:0], linkRx[15:8]};
    assign lastRec = (remain_r <= REC_LEN) || (recAddr_r >= ADDR_LAST_REC);
    assign useMode16 = present_r ? mode16_r : swMode16;

    always_comb begin
        cmdNxt.op = SEL_OP_READ;
        cmdNxt.mode16 = useMode16;
        cmdNxt.addr = ADDR_ID;
        cmdNxt.wdata = swData_r;
        cmdNxt.nbytes = ONE_BYTE;
        unique case (state_r)
            C_ID9: begin
                cmdNxt.mode16 = 1'b0;
                cmdNxt.nbytes = ID_BYTES;
            end
            C_ID16: begin
                cmdNxt.mode16 = 1'b1;
                cmdNxt.nbytes = ID_BYTES;
            end
            C_COUNT: begin
                cmdNxt.addr = ADDR_COUNT;
                cmdNxt.nbytes = COUNT_BYTES;
            end
            C_REC: begin
                cmdNxt.addr = recAddr_r[15:0];
                cmdNxt.nbytes = REC_BYTES;
            end
            C_IDLE: begin
                cmdNxt.addr = swAddr_r;
            end
            C_WRITE_LATCH_SET_COMMAND: begin
                cmdNxt.op = SEL_OP_WRITE_LATCH_SET_COMMAND;
            end
            C_WRITE: begin
                cmdNxt.op = SEL_OP_WRITE;
                cmdNxt.addr = swAddr_r;
            end
            C_POLL: begin
                cmdNxt.op = SEL_OP_STATUS_FETCH_COMMAND;
            end
            C_READ: begin
                cmdNxt.addr = swAddr_r;
            end
        endcase
    end

    // Request handshake: the command is held from the toggle until its acknowledge.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reqTgl_r <= 1'b0;
            pend_r <= 1'b0;
            cmd_r <= '0;
        end else if (pend_r) begin
            if (ackEv) begin
                pend_r <= 1'b0;
            end
        end else if (state_r != C_IDLE) begin
            cmd_r <= cmdNxt;
            reqTgl_r <= ~reqTgl_r;
            pend_r <= 1'b1;
        end
    end

    // Main sequencer for loading and software access.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= C_ID9;
            remain_r <= COUNT_ZERO;
            recAddr_r <= ADDR_FIRST_REC;
            swAddr_r <= 16'h0;
            swData_r <= 8'h0;
            mode16_r <= 1'b0;
            present_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            unique case (state_r)
                C_ID9: begin
                    if (pend_r && ackEv) begin
                        if (idRead == ID_CODE) begin
                            mode16_r <= 1'b0;
                            present_r <= 1'b1;
                            state_r <= C_COUNT;
                        end else begin
                            state_r <= C_ID16;
                        end
                    end
                end
                C_ID16: begin
                    if (pend_r && ackEv) begin
                        if (idRead == ID_CODE) begin
                            mode16_r <= 1'b1;
                            present_r <= 1'b1;
                            state_r <= C_COUNT;
                        end else begin
                            done_r <= 1'b1;
                            state_r <= C_IDLE;
                        end
                    end
                end
                C_COUNT: begin
                    if (pend_r && ackEv) begin
                        remain_r <= countRead;
                        recAddr_r <= ADDR_FIRST_REC;
                        if (countRead == COUNT_ZERO) begin
                            done_r <= 1'b1;
                            state_r <= C_IDLE;
                        end else begin
                            state_r <= C_REC;
                        end
                    end
                end
                C_REC: begin
                    if (pend_r && ackEv) begin
                        // A partial last record still counts whole, rounding the count up.
                        remain_r <= lastRec ? COUNT_ZERO : remain_r - REC_LEN;
                        recAddr_r <= recAddr_r + REC_STRIDE;
                        if (lastRec) begin
                            done_r <= 1'b1;
                            state_r <= C_IDLE;
                        end
                    end
                end
                C_IDLE: begin
                    if (swWriteReq) begin
                        swAddr_r <= swAddr;
                        swData_r <= swData;
                        state_r <= C_WRITE_LATCH_SET_COMMAND;
                    end else if (swReadReq) begin
                        swAddr_r <= swAddr;
                        state_r <= C_READ;
                    end
                end
                C_WRITE_LATCH_SET_COMMAND: begin
                    if (pend_r && ackEv) begin
                        state_r <= C_WRITE;
                    end
                end
                C_WRITE: begin
                    if (pend_r && ackEv) begin
                        state_r <= C_POLL;
                    end
                end
                C_POLL: begin
                    if (pend_r && ackEv && !linkRx[STATUS_BUSY_BIT]) begin
                        state_r <= C_IDLE;
                    end
                end
                C_READ: begin
                    if (pend_r && ackEv) begin
                        state_r <= C_IDLE;
                    end
                end
                default: state_r <= C_IDLE;
            endcase
        end
    end

    // Register write port; every target address is passed on unfiltered.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            csrWr <= '0;
            csrWrValid <= 1'b0;
        end else begin
            csrWrValid <= (state_r == C_REC) && pend_r && ackEv;
            if ((state_r == C_REC) && pend_r && ackEv) begin
                csrWr <= selDecodeRecord(linkRx);
            end
        end
    end

    // Software read result.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            swReadData <= 8'h0;
            swReadValid <= 1'b0;
        end else begin
            swReadValid <= (state_r == C_READ) && pend_r && ackEv;
            if ((state_r == C_READ) && pend_r && ackEv) begin
                swReadData <= linkRx[7:0];
            end
        end
    end

    // Completion kind for requests that arrive from the host side.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cplValid <= 1'b0;
            cplKind <= SEL_CPL_NORMAL;
        end else begin
            cplValid <= cfgReqValid;
            if (!done_r) begin
                cplKind <= cfgReqIsConfig ? SEL_CPL_RETRY : SEL_CPL_UNSUPPORTED;
            end else begin
                cplKind <= SEL_CPL_NORMAL;
            end
        end
    end

    assign loadDone = done_r;
    assign loadBusy = ~done_r;
    assign memPresent = present_r;
    assign addrMode16 = useMode16;
    assign swBusy = (state_r != C_IDLE);

endmodule // sel_loader

/* verif/sel_loader_assertions.sv */
// Purpose: Port-level checks for the configuration loader.
// Assumes: Bound to every sel_loader instance.
// Notes: Serial pin checks run on the link clock.
`timescale 1ns/10ps
module sel_loader_assertions import sel_pkg::*; (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic linkClk,
    input wire logic memSerialClock,
    input wire logic loaderSerialOut,
    input wire logic memSelectN,
    input wire logic csrWrValid,
    input wire logic loadBusy,
    input wire logic loadDone,
    input wire logic cfgReqValid,
    input wire logic cfgReqIsConfig,
    input wire logic cplValid,
    input wire sel_cpl_t cplKind
);
    sequence s_retryReq;
        cfgReqValid && cfgReqIsConfig && !loadDone;
    endsequence
    sequence s_clkHigh;
        memSerialClock [*8] ##1 !memSerialClock;
    endsequence
    property p_cplNext;
        @(posedge clk) disable iff (sys_rst) cfgReqValid |=> cplValid;
    endproperty
    property p_retry;
        @(posedge clk) disable iff (sys_rst) s_retryReq |=> cplKind == SEL_CPL_RETRY;
    endproperty
    property p_unsup;
        @(posedge clk) disable iff (sys_rst)
            cfgReqValid && !cfgReqIsConfig && !loadDone |=> cplKind == SEL_CPL_UNSUPPORTED;
    endproperty
    property p_normal;
        @(posedge clk) disable iff (sys_rst) cfgReqValid && loadDone |=> cplKind == SEL_CPL_NORMAL;
    endproperty
    property p_outFall;
        @(posedge linkClk) disable iff (sys_rst)
            !memSelectN && !$past(memSelectN) && $changed(loaderSerialOut) |-> $fell(memSerialClock);
    endproperty
    property p_idleLow;
        @(posedge linkClk) disable iff (sys_rst) memSelectN |-> !memSerialClock;
    endproperty
    property p_clkHigh;
        @(posedge linkClk) disable iff (sys_rst) $rose(memSerialClock) |-> s_clkHigh;
    endproperty
    property p_csrPulse;
        @(posedge clk) disable iff (sys_rst) csrWrValid |=> !csrWrValid;
    endproperty
    property p_wrWhileLoad;
        @(posedge clk) disable iff (sys_rst) csrWrValid |-> !$past(loadDone) && $past(loadBusy);
    endproperty
    a_cplNext: assert property (p_cplNext) else $error("no completion");
    a_retry: assert property (p_retry) else $error("retry expected");
    a_unsup: assert property (p_unsup) else $error("unsupported expected");
    a_normal: assert property (p_normal) else $error("normal expected");
    a_outFall: assert property (p_outFall) else $error("data moved off fall");
    a_idleLow: assert property (p_idleLow) else $error("clock not idle low");
    a_clkHigh: assert property (p_clkHigh) else $error("bad high phase");
    a_csrPulse: assert property (p_csrPulse) else $error("write pulse too long");
    a_wrWhileLoad: assert property (p_wrWhileLoad) else $error("write after load");
endmodule // sel_loader_assertions

bind sel_loader sel_loader_assertions chk (.clk, .sys_rst, .linkClk, .memSerialClock,
    .loaderSerialOut, .memSelectN, .csrWrValid, .loadBusy, .loadDone, .cfgReqValid,
    .cfgReqIsConfig, .cplValid, .cplKind);

/* verif/sel_mem_model.sv */
// Purpose: Serial memory with 16-bit addressing holding a small image.
// Assumes: Only reads are served; other instructions are sampled and ignored.
// Notes: The return line toggles on each falling serial clock before data is driven, and at each deselect.
`timescale 1ns/10ps
module sel_mem_model #(
    parameter logic [15:0] ID = 16'h0000,
    parameter logic [15:0] CNT = 16'h0000,
    parameter logic [47:0] REC = 48'h0
) (
    input wire logic memSerialClock,
    input wire logic loaderSerialOut,
    input wire logic memSelectN,
    output logic memorySerialReturn,
    output logic [7:0] lastOp,
    output logic [15:0] lastAddr
);
    localparam logic [79:0] IMG = {REC, CNT, ID};
    logic [23:0] hdr;
    logic [15:0] rdAddr;
    logic [7:0] sh;
    int nb;
    initial memorySerialReturn = 1'b0;
    always @(negedge memSelectN) nb = 0;
    always @(posedge memSelectN) memorySerialReturn = ~memorySerialReturn;
    always @(posedge memSerialClock) begin
        if (!memSelectN) begin
            hdr = {hdr[22:0], loaderSerialOut};
            nb++;
            if (nb == 24) begin
                lastOp = hdr[23:16];
                lastAddr = hdr[15:0];
                rdAddr = hdr[15:0];
            end
        end
    end
    always @(negedge memSerialClock) begin
        if (!memSelectN && nb >= 24) begin
            if (nb % 8 == 0) begin
                sh = (rdAddr < 16'h000a) ? IMG[8 * rdAddr +: 8] : 8'hff;
                rdAddr++;
            end else begin
                sh = {sh[6:0], 1'b0};
            end
            memorySerialReturn = sh[7];
        end else if (!memSelectN) begin
            memorySerialReturn = ~memorySerialReturn;
        end
    end
endmodule // sel_mem_model

/* verif/tb_top.sv */
// Purpose: Self-checking bench for the configuration loader.
// Assumes: The memory answers with 16-bit addressing only.
// Notes: One software read follows the load; software writes need a run of their own.
`timescale 1ns/10ps
module tb_top import sel_pkg::*; ;
    localparam logic [15:0] ID = 16'h5a3c;
    localparam logic [15:0] CNT = 16'h0005;
    localparam logic [47:0] REC = 48'h4433_2211_59c4;
    localparam int LIMIT = 99000;
    logic clk, sys_rst, linkClk, memSerialClock, loaderSerialOut, memSelectN;
    logic memorySerialReturn, csrWrValid, loadBusy, loadDone, memPresent, addrMode16;
    logic swBusy, swReadValid, cfgReqValid, cfgReqIsConfig, cplValid;
    logic [7:0] swReadData, lastOp;
    logic [15:0] lastAddr, swAddr;
    logic swReadReq;
    sel_csr_wr_t csrWr, gotWr;
    sel_cpl_t cplKind;
    int mismatches = 0, comparisons = 0, cycles = 0, nWr = 0;

    sel_loader #(.ID_CODE(ID)) dut (.clk, .sys_rst, .linkClk, .memSerialClock,
        .loaderSerialOut, .memSelectN, .memorySerialReturn, .csrWr, .csrWrValid,
        .loadBusy, .loadDone, .memPresent, .addrMode16, .swMode16(1'b0),
        .swWriteReq(1'b0), .swReadReq, .swAddr, .swData(8'h00),
        .swBusy, .swReadData, .swReadValid, .cfgReqValid, .cfgReqIsConfig,
        .cplValid, .cplKind);
    sel_mem_model #(.ID(ID), .CNT(CNT), .REC(REC)) mem (.memSerialClock,
        .loaderSerialOut, .memSelectN, .memorySerialReturn, .lastOp, .lastAddr);

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        linkClk = 1'b0;
        #17.3;
        forever #62.5 linkClk = ~linkClk;
    end
    always @(posedge clk) begin
        if (csrWrValid === 1'b1) begin
            nWr++;
            gotWr = csrWr;
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            mismatches++;
            conclude();
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic cfg_req(input logic isCfg, input sel_cpl_t kind);
        @(posedge clk);
        #1;
        cfgReqValid = 1'b1;
        cfgReqIsConfig = isCfg;
        @(posedge clk);
        #1;
        cfgReqValid = 1'b0;
        check(cplValid, 1'b1);
        check(cplKind, kind);
    endtask
    task automatic test_during_load();
        cfg_req(1'b1, SEL_CPL_RETRY);
        cfg_req(1'b0, SEL_CPL_UNSUPPORTED);
        check(loadBusy, 1'b1);
        $display("test_during_load finished");
    endtask
    // The identity only matches on the 16-bit retry, and a count of five rounds to one record.
    task automatic test_image();
        int n;
        n = 0;
        while (loadDone !== 1'b1 && n < 90000) begin
            @(posedge clk);
            n++;
        end
        #1;
        check(loadDone, 1'b1);
        check(loadBusy, 1'b0);
        check(memPresent, 1'b1);
        check(addrMode16, 1'b1);
        check(nWr, 1);
        check(gotWr, {12'h9c4, 4'h5, 32'h4433_2211});
        check(lastOp, OPC_READ);
        check(lastAddr, 16'h0004);
        $display("test_image finished");
    endtask
    task automatic test_after_load();
        cfg_req(1'b1, SEL_CPL_NORMAL);
        cfg_req(1'b0, SEL_CPL_NORMAL);
        $display("test_after_load finished");
    endtask
    // Byte five of the image is the packed enable and high address byte of the record.
    task automatic test_sw_read();
        int n;
        n = 0;
        @(posedge clk);
        #1;
        swAddr = 16'h0005;
        swReadReq = 1'b1;
        @(posedge clk);
        #1;
        swReadReq = 1'b0;
        check(swBusy, 1'b1);
        while (swReadValid !== 1'b1 && n < 20000) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(swReadValid, 1'b1);
        check(swReadData, 8'h59);
        check(swBusy, 1'b0);
        check(lastOp, OPC_READ);
        check(lastAddr, 16'h0005);
        $display("test_sw_read finished");
    endtask

    initial begin
        sys_rst = 1'b1;
        cfgReqValid = 1'b0;
        cfgReqIsConfig = 1'b0;
        swReadReq = 1'b0;
        swAddr = 16'h0000;
        repeat (20) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        test_during_load();
        test_image();
        test_after_load();
        test_sw_read();
        conclude();
    end
endmodule // tb_top
